// *** design/aeif_pkg.sv ***
/*
  Constants, register map and types of the converter error/interrupt flag block.
  Assumes a 32-bit APB with one aligned word per register.
*/
package aeif_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is index shifted left)
  // ----------------------------------------------------------------
  localparam logic [7:0] EIE_IDX = 8'h06;
  localparam logic [7:0] IE_IDX = 8'h07;
  localparam logic [7:0] EIF_IDX = 8'h08;
  localparam int ADDR_SHIFT = 2;

  // ----------------------------------------------------------------
  // Bit positions
  // ----------------------------------------------------------------
  localparam int BAD_ACCESS_BIT = 7;
  localparam int BAD_COMMAND_BIT = 6;
  localparam int LIST_END_BIT = 5;
  localparam int TRIGGER_BIT = 3;
  localparam int RESTART_REQ_BIT = 2;
  localparam int LOAD_OK_BIT = 1;
  localparam int ABORT_DONE_BIT = 7;
  localparam int OVERRUN_BIT = 6;

  // ----------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] EIE_MASK = 8'hEE;
  localparam logic [7:0] IE_MASK = 8'hC0;
  localparam logic [7:0] EIF_IMPL_MASK = 8'hEE;
  localparam logic [7:0] EIF_SW_MASK = 8'h06;
  localparam logic [7:0] SEVERE_MASK = 8'hE8;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] FORMAT_RSVD_DEFAULT = 8'hE0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {SEQ_IDLE, SEQ_RUNNING} aeif_seq_t;

endpackage

// *** design/aeif_regbus_if.sv ***
/*
  Internal register-access carrier between the APB slave and the flag core.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface aeif_regbus_if;
  logic wr_eie;
  logic wr_ie;
  logic wr_eif;
  logic [7:0] wdata;
  logic [7:0] eie;
  logic [7:0] ie;
  logic [7:0] eif;
  modport bus (output wr_eie, output wr_ie, output wr_eif, output wdata,
               input eie, input ie, input eif);
  modport core (input wr_eie, input wr_ie, input wr_eif, input wdata,
                output eie, output ie, output eif);
endinterface

// *** design/aeif_flag_cell.sv ***
/*
  One sticky error flag: hardware set, optional write-one clear, forced clear.
  Assumes clear inputs are already qualified by the caller.
*/
`timescale 1ns/10ps
module aeif_flag_cell #(
  parameter bit SW_CLEARABLE = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Control
  input wire logic set,
  input wire logic sw_clr,
  input wire logic hw_clr,
  // Flag
  output logic flag
);
  logic flag_next;
  // Forced clear first, then set over software clear
  assign flag_next = hw_clr ? 1'b0 :
                     set ? 1'b1 :
                     (SW_CLEARABLE && sw_clr) ? 1'b0 : flag;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (clk_en) begin
      flag <= flag_next;
    end
  end
endmodule // aeif_flag_cell

// *** design/aeif_apb.sv ***
/*
  APB slave for the three byte-wide registers.
  Assumes pclk domain; data sit in the low byte of each word.
*/
`timescale 1ns/10ps
module aeif_apb #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Register side
  aeif_regbus_if.bus rb
);
  localparam logic [ADDR_W-1:0] EIE_ADDR = ADDR_W'(aeif_pkg::EIE_IDX) << aeif_pkg::ADDR_SHIFT;
  localparam logic [ADDR_W-1:0] IE_ADDR = ADDR_W'(aeif_pkg::IE_IDX) << aeif_pkg::ADDR_SHIFT;
  localparam logic [ADDR_W-1:0] EIF_ADDR = ADDR_W'(aeif_pkg::EIF_IDX) << aeif_pkg::ADDR_SHIFT;

  logic rd_valid_reg;
  logic hit_eie;
  logic hit_ie;
  logic hit_eif;
  logic mapped;
  logic access_done;
  logic [7:0] rd_sel;

  assign hit_eie = (paddr == EIE_ADDR);
  assign hit_ie = (paddr == IE_ADDR);
  assign hit_eif = (paddr == EIF_ADDR);
  assign mapped = hit_eie | hit_ie | hit_eif;
  // Read data must have been sampled once before the access completes
  assign pready = psel & penable & clk_en & rd_valid_reg;
  assign pslverr = pready & ~mapped;
  assign access_done = pready & pwrite & mapped;
  assign rb.wr_eie = access_done & hit_eie;
  assign rb.wr_ie = access_done & hit_ie;
  assign rb.wr_eif = access_done & hit_eif;
  assign rb.wdata = pwdata[7:0];
  assign rd_sel = hit_eie ? rb.eie : hit_ie ? rb.ie : hit_eif ? rb.eif : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      rd_valid_reg <= 1'b0;
    end else if (clk_en) begin
      prdata <= {24'h00_0000, rd_sel};
      rd_valid_reg <= psel & ~pready;
    end
  end
endmodule // aeif_apb

// *** design/aeif_top.sv ***
/*
  Error/interrupt enable and error flag logic of a list-driven converter.
  Assumes event inputs are single-cycle pulses synchronous to pclk.
*/
// Implementation choice: the APB register port.
`timescale 1ns/10ps
module aeif_top #(
  parameter int ADDR_W = 8,
  parameter logic [7:0] FORMAT_RSVD = aeif_pkg::FORMAT_RSVD_DEFAULT
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter control
  input wire logic module_enable,
  input wire logic soft_reset,
  input wire logic restart_mode,
  input wire logic single_buffer_mode,
  // Severe error events
  input wire logic result_store_fault,
  input wire logic cmd_fetch_outside,
  input wire logic cmd_load,
  input wire logic cmd_reserved_bits,
  input wire logic [2:0] result_format_select,
  input wire logic list_end_missing,
  input wire logic trigger_fault,
  // Flow control events
  input wire logic trigger_event,
  input wire logic restart_req,
  input wire logic list_end_done,
  input wire logic list_aborted,
  input wire logic alt_list_loaded,
  input wire logic abort_active,
  input wire logic abort_req,
  // Normal interrupt flags from outside
  input wire logic abort_done_flag,
  input wire logic complete_flag_overrun,
  // Results
  output logic conv_halt,
  output logic err_irq,
  output logic norm_irq
);

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  aeif_regbus_if rb ();

  aeif_apb #(.ADDR_W(ADDR_W)) u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rb(rb.bus)
  );

  // ----------------------------------------------------------------
  // Enable registers
  // ----------------------------------------------------------------
  logic [7:0] error_irq_enable_reg;
  logic [7:0] error_irq_enable_next;
  logic [7:0] irq_enable_reg;
  logic [7:0] irq_enable_next;

  assign error_irq_enable_next = rb.wr_eie ? (rb.wdata & aeif_pkg::EIE_MASK)
                                           : error_irq_enable_reg;
  assign irq_enable_next = rb.wr_ie ? (rb.wdata & aeif_pkg::IE_MASK) : irq_enable_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_irq_enable_reg <= aeif_pkg::REG_RESET;
      irq_enable_reg <= aeif_pkg::REG_RESET;
    end else if (clk_en) begin
      error_irq_enable_reg <= error_irq_enable_next;
      irq_enable_reg <= irq_enable_next;
    end
  end

  // ----------------------------------------------------------------
  // Sequence tracking
  // ----------------------------------------------------------------
  aeif_pkg::aeif_seq_t seq_reg;
  aeif_pkg::aeif_seq_t seq_next;
  logic first_restart_seen_reg;
  logic block_clear;

  assign block_clear = ~module_enable | soft_reset;

  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      aeif_pkg::SEQ_IDLE: begin
        if (trigger_event) begin
          seq_next = aeif_pkg::SEQ_RUNNING;
        end
      end
      aeif_pkg::SEQ_RUNNING: begin
        if (list_end_done || list_aborted || abort_req) begin
          seq_next = aeif_pkg::SEQ_IDLE;
        end
      end
      default: begin
        seq_next = aeif_pkg::SEQ_IDLE;
      end
    endcase
    if (block_clear) begin
      seq_next = aeif_pkg::SEQ_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= aeif_pkg::SEQ_IDLE;
      first_restart_seen_reg <= 1'b0;
    end else if (clk_en) begin
      seq_reg <= seq_next;
      first_restart_seen_reg <= ~block_clear & (first_restart_seen_reg | restart_req);
    end
  end

  // ----------------------------------------------------------------
  // Flag set and clear terms
  // ----------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] flag_sw_clr;
  logic [7:0] error_flags;
  logic format_reserved;
  logic restart_err;
  logic load_ok_err;

  assign format_reserved = FORMAT_RSVD[result_format_select];
  assign restart_err = restart_req & (seq_reg == aeif_pkg::SEQ_RUNNING)
                       & ~list_end_done & ~list_aborted & ~abort_req;
  assign load_ok_err = restart_req & restart_mode & ~alt_list_loaded & ~abort_active
                       & ~abort_req & first_restart_seen_reg & ~single_buffer_mode;

  always_comb begin
    flag_set = 8'h00;
    flag_set[aeif_pkg::BAD_ACCESS_BIT] = result_store_fault | cmd_fetch_outside;
    flag_set[aeif_pkg::BAD_COMMAND_BIT] = cmd_load & (cmd_reserved_bits | format_reserved);
    flag_set[aeif_pkg::LIST_END_BIT] = list_end_missing;
    flag_set[aeif_pkg::TRIGGER_BIT] = trigger_fault;
    flag_set[aeif_pkg::RESTART_REQ_BIT] = restart_err;
    flag_set[aeif_pkg::LOAD_OK_BIT] = load_ok_err;
  end

  // Only restart and load-ok positions accept write-one clear
  assign flag_sw_clr = rb.wr_eif ? (rb.wdata & aeif_pkg::EIF_SW_MASK) : 8'h00;

  // ----------------------------------------------------------------
  // Flag cells
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      if (aeif_pkg::EIF_IMPL_MASK[gi]) begin : g_cell
        aeif_flag_cell #(.SW_CLEARABLE(aeif_pkg::EIF_SW_MASK[gi])) u_cell (
          .pclk(pclk),
          .presetn(presetn),
          .clk_en(clk_en),
          .set(flag_set[gi]),
          .sw_clr(flag_sw_clr[gi]),
          .hw_clr(block_clear),
          .flag(error_flags[gi])
        );
      end else begin : g_none
        assign error_flags[gi] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rb.eie = error_irq_enable_reg;
  assign rb.ie = irq_enable_reg;
  assign rb.eif = error_flags;

  // Restart and load-ok flags are outside the halting mask
  assign conv_halt = |(error_flags & aeif_pkg::SEVERE_MASK);
  // Enable positions line up with flag positions
  assign err_irq = |(error_flags & error_irq_enable_reg);
  assign norm_irq = (abort_done_flag & irq_enable_reg[aeif_pkg::ABORT_DONE_BIT])
                  | (complete_flag_overrun & irq_enable_reg[aeif_pkg::OVERRUN_BIT]);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_seq_started;
    clk_en && trigger_event && !list_end_done && !list_aborted && !abort_req && module_enable && !soft_reset;
  endsequence

  sequence s_restart_while_running;
    clk_en && restart_req && !list_end_done && !list_aborted && !abort_req && module_enable && !soft_reset;
  endsequence

  sequence s_quiet_running;
    clk_en && !list_end_done && !list_aborted && !abort_req && !restart_req && module_enable && !soft_reset;
  endsequence

  sequence s_apb_setup;
    clk_en && psel && !penable;
  endsequence

  sequence s_apb_access;
    clk_en && psel && penable;
  endsequence

  severe_halts_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(error_flags[aeif_pkg::TRIGGER_BIT]) |-> conv_halt)
    else $error("severe flag did not halt");

  soft_mild_a: assert property (@(posedge pclk) disable iff (!presetn)
    (error_flags & aeif_pkg::SEVERE_MASK) == 8'h00 |-> !conv_halt)
    else $error("mild flag halted converter");

  soft_reset_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && soft_reset |=> error_flags == 8'h00 && !conv_halt)
    else $error("soft reset left a flag");

  disabled_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !module_enable) [*2] |-> error_flags == 8'h00)
    else $error("flags set while disabled");

  write_zero_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && rb.wr_eif && rb.wdata == 8'h00 && !block_clear
    |=> (error_flags & $past(error_flags)) == $past(error_flags))
    else $error("write zero cleared a flag");

  severe_no_sw_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && rb.wr_eif && !block_clear
    && (flag_set & aeif_pkg::SEVERE_MASK) == 8'h00
    |=> (error_flags & aeif_pkg::SEVERE_MASK) == ($past(error_flags) & aeif_pkg::SEVERE_MASK))
    else $error("severe flag changed by write");

  w1c_mild_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && rb.wr_eif && rb.wdata[aeif_pkg::LOAD_OK_BIT] && !load_ok_err
    |=> !error_flags[aeif_pkg::LOAD_OK_BIT])
    else $error("write one did not clear");

  restart_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_seq_started ##1 s_quiet_running [*2] ##1 s_restart_while_running
    |=> error_flags[aeif_pkg::RESTART_REQ_BIT])
    else $error("restart error not flagged");

  load_ok_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && restart_req && !restart_mode && !error_flags[aeif_pkg::LOAD_OK_BIT]
    |=> !error_flags[aeif_pkg::LOAD_OK_BIT])
    else $error("load-ok flag outside restart mode");

  bad_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && cmd_load && cmd_reserved_bits && !block_clear
    |=> error_flags[aeif_pkg::BAD_COMMAND_BIT] && conv_halt)
    else $error("bad command not flagged");

  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(error_flags[aeif_pkg::BAD_ACCESS_BIT]) && error_irq_enable_reg[aeif_pkg::BAD_ACCESS_BIT]
    |-> err_irq)
    else $error("error interrupt missing");

  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rb.eif & ~aeif_pkg::EIF_IMPL_MASK) == 8'h00 && (rb.eie & ~aeif_pkg::EIE_MASK) == 8'h00)
    else $error("reserved bit reads one");

  apb_zero_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup ##1 s_apb_access |-> pready)
    else $error("access phase not answered");

  enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && rb.wr_eie |=> error_irq_enable_reg == ($past(rb.wdata) & aeif_pkg::EIE_MASK))
    else $error("enable write lost");

  clk_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(error_flags) && $stable(error_irq_enable_reg) && $stable(irq_enable_reg))
    else $error("state moved while frozen");

  w1c_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && rb.wr_eif && rb.wdata[aeif_pkg::RESTART_REQ_BIT] && !restart_err
    |=> !error_flags[aeif_pkg::RESTART_REQ_BIT])
    else $error("write one did not clear restart flag");

  w1_no_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && rb.wr_eif && !load_ok_err && !error_flags[aeif_pkg::LOAD_OK_BIT]
    |=> !error_flags[aeif_pkg::LOAD_OK_BIT])
    else $error("write set a flag");

  bad_access_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (result_store_fault || cmd_fetch_outside) && !block_clear
    |=> error_flags[aeif_pkg::BAD_ACCESS_BIT] && conv_halt)
    else $error("bad access not flagged");

  list_end_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && list_end_missing && !block_clear
    |=> error_flags[aeif_pkg::LIST_END_BIT] && conv_halt)
    else $error("missing list end not flagged");

  trigger_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && trigger_fault && !block_clear |=> error_flags[aeif_pkg::TRIGGER_BIT] && conv_halt)
    else $error("trigger error not flagged");

  norm_irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !irq_enable_reg[aeif_pkg::ABORT_DONE_BIT] && !irq_enable_reg[aeif_pkg::OVERRUN_BIT]
    |-> !norm_irq)
    else $error("masked normal interrupt raised");

  err_irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (error_flags & error_irq_enable_reg) == 8'h00 |-> !err_irq)
    else $error("masked error interrupt raised");

endmodule // aeif_top

// *** bench/adc_error_interrupt_flags_test.sv ***
/*
  Self-checking bench of the converter error/interrupt flag block.
  Assumes aeif_top with its APB slave and pulse event inputs on pclk.
*/
`timescale 1ns/10ps
module adc_error_interrupt_flags_test;
  // ----------------------------------------------------------------
  // Stimulus and model state
  // ----------------------------------------------------------------
  localparam logic [7:0] A_EIE = 8'(aeif_pkg::EIE_IDX << aeif_pkg::ADDR_SHIFT);
  localparam logic [7:0] A_IE = 8'(aeif_pkg::IE_IDX << aeif_pkg::ADDR_SHIFT);
  localparam logic [7:0] A_EIF = 8'(aeif_pkg::EIF_IDX << aeif_pkg::ADDR_SHIFT);
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, conv_halt, err_irq, norm_irq;
  logic [10:0] ev = 11'h000;
  logic clk_en = 1'b1;
  logic module_enable = 1'b1;
  logic restart_mode = 1'b0;
  logic single_buffer_mode = 1'b0;
  logic cmd_reserved_bits = 1'b0;
  logic alt_list_loaded = 1'b0;
  logic abort_active = 1'b0;
  logic abort_done_flag = 1'b0;
  logic complete_flag_overrun = 1'b0;
  logic [2:0] fmt = 3'h0;
  logic [7:0] m_eie = 8'h00;
  logic [7:0] m_ie = 8'h00;
  logic [7:0] m_eif = 8'h00;
  int n_errors = 0;
  int n_compared = 0;
  int unsigned seed = 13908;
  int sev_bit[5] = '{7, 7, 6, 5, 3};

  always #12.5 pclk = ~pclk;

  aeif_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .module_enable(module_enable), .soft_reset(ev[9]), .restart_mode(restart_mode),
    .single_buffer_mode(single_buffer_mode), .result_store_fault(ev[0]), .cmd_fetch_outside(ev[1]),
    .cmd_load(ev[2]), .cmd_reserved_bits(cmd_reserved_bits), .result_format_select(fmt),
    .list_end_missing(ev[3]), .trigger_fault(ev[4]), .trigger_event(ev[5]), .restart_req(ev[6]),
    .list_end_done(ev[7]), .list_aborted(ev[10]), .alt_list_loaded(alt_list_loaded),
    .abort_active(abort_active), .abort_req(ev[8]), .abort_done_flag(abort_done_flag),
    .complete_flag_overrun(complete_flag_overrun), .conv_halt(conv_halt), .err_irq(err_irq),
    .norm_irq(norm_irq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Look at the answer mid-cycle, then let its sampling edge pass
    for (i = 0; i < 16; i++) begin
      @(negedge pclk);
      if (pready === 1'b1) begin
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        break;
      end
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      n_errors++;
      $display("mismatch pready expected 1 seen 0");
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic bad = 1'b0);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    cmp("pslverr", bad, err);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e, input logic bad = 1'b0);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    cmp(nm, {24'h0, e}, rd);
    cmp("pslverr", bad, err);
  endtask

  task automatic check_flags();
    rd_chk("error_flags", A_EIF, m_eif);
    cmp("conv_halt", 32'(|(m_eif & 8'hE8)), 32'(conv_halt));
    cmp("err_irq", 32'(|(m_eif & m_eie)), 32'(err_irq));
  endtask

  // One-cycle pulse on an event input; flag settles after the sampling edge
  task automatic fire(input int k);
    @(posedge pclk);
    ev[k] <= 1'b1;
    @(posedge pclk);
    ev[k] <= 1'b0;
    #1;
    if (k == 9) m_eif = 8'h00;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check_flags();
    rd_chk("error_irq_enable", A_EIE, 8'h00);
    rd_chk("irq_enable", A_IE, 8'h00);
    wr(A_EIE, 32'hFFFF_FFFF);
    m_eie = 8'hEE;
    rd_chk("error_irq_enable", A_EIE, m_eie);
    wr(A_IE, 32'h0000_00FF);
    m_ie = 8'hC0;
    rd_chk("irq_enable", A_IE, m_ie);
    wr(8'h24, 32'h0000_00FF, 1'b1);
    rd_chk("unmapped", 8'h24, 8'h00, 1'b1);
    $display("test registers done");
    for (int k = 0; k < 5; k++) begin
      fire(9);
      m_eie = 8'(xs()) & 8'hEE;
      wr(A_EIE, {24'h0, m_eie});
      @(posedge pclk);
      cmd_reserved_bits <= (k == 2);
      fire(k);
      m_eif[sev_bit[k]] = 1'b1;
      check_flags();
      wr(A_EIF, 32'h0000_00FF);
      check_flags();
    end
    $display("test severe errors done");
    for (int f = 0; f < 8; f++) begin
      fire(9);
      check_flags();
      @(posedge pclk);
      fmt <= f[2:0];
      cmd_reserved_bits <= (f == 1);
      fire(2);
      m_eif[6] = (f == 1) || aeif_pkg::FORMAT_RSVD_DEFAULT[f];
      check_flags();
    end
    @(posedge pclk);
    fmt <= 3'h0;
    cmd_reserved_bits <= 1'b0;
    $display("test command formats done");
    fire(9);
    m_eie = 8'h06;
    wr(A_EIE, {24'h0, m_eie});
    fire(5);
    @(posedge pclk);
    fire(6);
    m_eif[2] = 1'b1;
    check_flags();
    wr(A_EIF, 32'h0000_0000);
    check_flags();
    wr(A_EIF, 32'h0000_0004);
    m_eif[2] = 1'b0;
    check_flags();
    wr(A_EIF, 32'h0000_00FF);
    check_flags();
    fire(7);
    fire(6);
    check_flags();
    fire(5);
    fire(8);
    fire(6);
    check_flags();
    fire(5);
    fire(10);
    fire(6);
    check_flags();
    $display("test restart error done");
    fire(9);
    @(posedge pclk);
    restart_mode <= 1'b1;
    fire(6);
    check_flags();
    fire(6);
    m_eif[1] = 1'b1;
    check_flags();
    wr(A_EIF, 32'h0000_0002);
    m_eif[1] = 1'b0;
    check_flags();
    for (int s = 0; s < 4; s++) begin
      @(posedge pclk);
      alt_list_loaded <= (s == 0);
      abort_active <= (s == 1);
      single_buffer_mode <= (s == 2);
      fire(6);
      m_eif[1] = (s == 3);
      check_flags();
    end
    fire(9);
    check_flags();
    $display("test load ok error done");
    fire(4);
    fire(5);
    fire(6);
    m_eif = 8'h0C;
    check_flags();
    @(posedge pclk);
    module_enable <= 1'b0;
    fire(0);
    fire(4);
    m_eif = 8'h00;
    check_flags();
    @(posedge pclk);
    module_enable <= 1'b1;
    restart_mode <= 1'b0;
    clk_en <= 1'b0;
    // Event while frozen must leave no flag
    fire(4);
    @(posedge pclk);
    clk_en <= 1'b1;
    check_flags();
    $display("test module enable done");
    for (int j = 0; j < 12; j++) begin
      m_ie = 8'(xs()) & 8'hC0;
      wr(A_IE, {24'h0, (8'(xs()) | m_ie) & (m_ie | 8'h3F)});
      @(posedge pclk);
      abort_done_flag <= j[0];
      complete_flag_overrun <= j[1];
      @(posedge pclk);
      #1;
      cmp("norm_irq", 32'((j[0] & m_ie[7]) | (j[1] & m_ie[6])), 32'(norm_irq));
    end
    rd_chk("irq_enable", A_IE, m_ie);
    $display("test normal interrupts done");
    report_and_stop();
  end

  initial begin
    #1000000;
    n_errors++;
    $display("mismatch run_time expected end seen timeout");
    report_and_stop();
  end
endmodule // adc_error_interrupt_flags_test
